// ---- rtl/pdmc_map.vh ----
// constants of the power-down mode controller: register map, fields, states
// assumes a 32-bit AXI4-Lite register bus and an 8-bit watchdog counter
`ifndef PDMC_MAP_VH
`define PDMC_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PDMC_OFS_STANDBY_SELECT_BIT_CTRL 8'h00
`define PDMC_OFS_MSTOP     8'h04
`define PDMC_OFS_WDOG_CTRL 8'h08
`define PDMC_OFS_WDOG_CNT  8'h0c
`define PDMC_OFS_STATUS    8'h10
`define PDMC_OFS_EVT_A     8'h14
`define PDMC_OFS_EVT_B     8'h18

// ****************************************************************
// field positions and widths
// ****************************************************************
`define PDMC_STANDBY_SELECT_BIT_BIT      0
`define PDMC_RTC_USE_BIT   1
`define PDMC_WDOG_RUN_BIT  7
`define PDMC_WDOG_SEL_HI   2
`define PDMC_WDOG_SEL_LO   0
`define PDMC_STAT_PWAKE    4
`define PDMC_STAT_HWREQ    5
`define PDMC_MSTOP_W       16
`define PDMC_EVT_W         12
`define PDMC_CNT_W         8
`define PDMC_PRE_W         16
`define PDMC_ST_W          3

// ****************************************************************
// reset values and counter marks
// ****************************************************************
`define PDMC_MSTOP_RST     16'h0000
`define PDMC_CNT_RST       8'h00
`define PDMC_CNT_REENTER   8'h80
`define PDMC_CNT_LAST      8'hff
`define PDMC_PRE_RST       16'h0000
`define PDMC_EVT_RST       12'h000

// ****************************************************************
// mode states
// ****************************************************************
`define PDMC_S_RUN         3'h0
`define PDMC_S_SLEEP       3'h1
`define PDMC_S_SWSTBY      3'h2
`define PDMC_S_SETTLE      3'h3
`define PDMC_S_HWSTBY      3'h4

// ****************************************************************
// bus responses
// ****************************************************************
`define PDMC_RESP_OKAY     2'h0
`define PDMC_RESP_SLVERR   2'h2

`endif

// ---- rtl/pdmc_ca_sampler.v ----
// hw standby pin sampler, stepped by rtc crystal edges
// assumes rtc_crystal_input and hw_standby_pin are synchronous to clk
`default_nettype none

module pdmc_hws_sampler (
	// clock and reset
	input  wire clk,
	input  wire reset_n,
	input  wire ce,
	// pins
	input  wire rtc_crystal_input,
	input  wire hw_standby_pin,
	// request
	output reg  request_q
);

	reg rtc_prev_q;
	reg low_seen_q;

	// two lows at rtc rising edges make a request
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rtc_prev_q <= 1'b0;
			low_seen_q <= 1'b0;
			request_q  <= 1'b0;
		end else if (ce) begin
			rtc_prev_q <= rtc_crystal_input;
			if (rtc_crystal_input && !rtc_prev_q) begin
				low_seen_q <= !hw_standby_pin;
				if (!hw_standby_pin && low_seen_q)
					request_q <= 1'b1; // held until power-on reset
			end
		end
	end

endmodule // pdmc_hws_sampler

`default_nettype wire

// ---- rtl/pdmc_top.v ----
// power-down mode controller: sleep, software standby, module stop, hw standby
// assumes cpu, interrupt and reset inputs are synchronous to clk;
// reset_n is the power-on reset, manual_reset_n a synchronous level
`default_nettype none
`include "pdmc_map.vh"

// Function
// - sleep with standby bit 0 enters sleep; cpu halts, clock out runs
// - sleep drives upper state pin high, lower low
// - sleep wakes on nmi, external, level, port, peripheral irqs, ignoring block bit
// - interrupt wake starts exception and loads both event code registers
// - power-on or manual reset ends sleep
// - sleep instruction with standby bit 1 stops cpu, clocks, peripherals, clock out
// - software standby drives upper state pin low, lower high
// - standby wakes on nmi, rtc-gated ext, level, port, rtc irqs, or reset
// - after watchdog settle, clocks return, pins low, exception, code recorded
// - counter stops when standby cleared unless watchdog run bit set, else re-enters at 80, manual reset refused
// - standby accepts wake irqs even with block bit set
// - module stop bit 1 gates that peripheral clock, registers hold
// - clearing a stop bit or power-on reset restores the clock
// - hw standby pin low halts all but rtc, ignores irqs and manual reset
// - from sleep or settle resume first; from standby enter hw standby directly
// - hw standby pin sampled on rtc clock, two lows required
// - hw standby ends only by power-on reset
// - stop bits reset to 0, gating only when written 1
module pdmc_top (
	// clock, reset, enable
	input  wire                      clk,
	input  wire                      reset_n,
	input  wire                      ce,
	// axi4-lite write address and data
	input  wire [7:0]                s_axi_awaddr,
	input  wire                      s_axi_awvalid,
	output reg                       s_axi_awready,
	input  wire [31:0]               s_axi_wdata,
	input  wire [3:0]                s_axi_wstrb,
	input  wire                      s_axi_wvalid,
	output reg                       s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]                s_axi_bresp,
	output reg                       s_axi_bvalid,
	input  wire                      s_axi_bready,
	// axi4-lite read
	input  wire [7:0]                s_axi_araddr,
	input  wire                      s_axi_arvalid,
	output reg                       s_axi_arready,
	output reg  [31:0]               s_axi_rdata,
	output reg  [1:0]                s_axi_rresp,
	output reg                       s_axi_rvalid,
	input  wire                      s_axi_rready,
	// cpu and interrupt sources
	input  wire                      sleep_exec,
	input  wire                      nmi_irq,
	input  wire                      ext_irq,
	input  wire                      encoded_level_irq,
	input  wire                      port_irq,
	input  wire                      periph_irq,
	input  wire                      rtc_irq,
	input  wire [`PDMC_EVT_W-1:0]    irq_code,
	// reset and standby pins
	input  wire                      manual_reset_n,
	input  wire                      rtc_crystal_input,
	input  wire                      hw_standby_pin,
	// state pins and clock gates
	output reg                       power_state_pin_hi,
	output reg                       power_state_pin_lo,
	output reg                       clock_output_en,
	output reg                       cpu_clk_en,
	output reg                       periph_clk_en,
	output reg  [`PDMC_MSTOP_W-1:0]  module_clk_en,
	// exception and reset requests
	output reg                       exception_start,
	output reg  [`PDMC_EVT_W-1:0]    event_code,
	output reg                       manual_reset_req,
	output reg                       hw_standby_active
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	reg  [`PDMC_ST_W-1:0]    state_q;
	reg  [`PDMC_ST_W-1:0]    state_d;
	reg                      standby_select_bit_q;
	reg                      rtc_use_q;
	reg  [`PDMC_MSTOP_W-1:0] mstop_q;
	reg                      wdog_run_q;
	reg  [2:0]               wdog_sel_q;
	reg  [`PDMC_CNT_W-1:0]   cnt_q;
	reg  [`PDMC_PRE_W-1:0]   pre_q;
	reg                      pwake_q;
	reg  [`PDMC_EVT_W-1:0]   evt_a_q;
	reg  [`PDMC_EVT_W-1:0]   evt_b_q;
	reg                      aw_have_q;
	reg                      w_have_q;
	reg  [7:0]               aw_addr_q;
	reg  [31:0]              w_data_q;
	reg  [3:0]               w_strb_q;
	reg  [31:0]              rd_d;
	reg                      rd_hit;
	wire                     hw_req;
	wire                     tick;
	wire                     cnt_run;
	wire                     settle_done;
	wire                     sleep_wake;
	wire                     standby_select_bit_wake;
	wire                     mreset_ok;
	wire                     do_write;
	wire [31:0]              wmix_standby_select_bit;
	wire [31:0]              wmix_mstop;
	wire [31:0]              wmix_wctl;
	wire [31:0]              wmix_cnt;

	// ****************************************************************
	// helper functions
	// ****************************************************************
	// merge write data by byte strobes
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer      i;
		begin
			wmerge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					wmerge[i*8 +: 8] = data[i*8 +: 8];
			end
		end
	endfunction

	// prescaler mask for a division select
	function [`PDMC_PRE_W-1:0] pre_mask;
		input [2:0] sel;
		begin
			pre_mask = ~({`PDMC_PRE_W{1'b1}} << ({1'b0, sel} << 1));
		end
	endfunction

	// ****************************************************************
	// hardware standby pin sampler
	// ****************************************************************
	pdmc_hws_sampler u_hws_sampler (
		.clk               (clk),
		.reset_n           (reset_n),
		.ce                (ce),
		.rtc_crystal_input (rtc_crystal_input),
		.hw_standby_pin    (hw_standby_pin),
		.request_q         (hw_req)
	);

	// ****************************************************************
	// wake decode and watchdog timing
	// ****************************************************************
	// block bit is no input, so it never blocks a wake
	assign sleep_wake = nmi_irq | ext_irq | encoded_level_irq | port_irq
		| periph_irq;
	// standby wake: nmi, others only with rtc
	assign standby_select_bit_wake = nmi_irq | (rtc_use_q
		& (ext_irq | encoded_level_irq | port_irq | rtc_irq));
	assign tick = ((pre_q & pre_mask(wdog_sel_q)) == pre_mask(wdog_sel_q));
	assign cnt_run = wdog_run_q | (state_q == `PDMC_S_SETTLE) | pwake_q;
	assign settle_done = tick && (cnt_q == `PDMC_CNT_LAST);
	// manual reset refused in hw standby or armed re-entry
	assign mreset_ok = !manual_reset_n && (state_q != `PDMC_S_HWSTBY)
		&& !(pwake_q && standby_select_bit_q);

	// ****************************************************************
	// mode state machine
	// ****************************************************************
	// next mode from the current one
	always @* begin
		state_d = state_q;
		case (state_q)
			`PDMC_S_RUN: begin
				if (hw_req)
					state_d = `PDMC_S_HWSTBY;
				else if (pwake_q && standby_select_bit_q && tick && cnt_q + 8'h01 == `PDMC_CNT_REENTER)
					state_d = `PDMC_S_SWSTBY;
				else if (sleep_exec && !standby_select_bit_q)
					state_d = `PDMC_S_SLEEP;
				else if (sleep_exec && standby_select_bit_q)
					state_d = `PDMC_S_SWSTBY;
			end
			`PDMC_S_SLEEP: begin
				if (hw_req || sleep_wake)
					state_d = `PDMC_S_RUN; // resume first
			end
			`PDMC_S_SWSTBY: begin
				if (hw_req)
					state_d = `PDMC_S_HWSTBY; // direct, clocks stopped
				else if (standby_select_bit_wake)
					state_d = `PDMC_S_SETTLE;
			end
			`PDMC_S_SETTLE: begin
				if (settle_done)
					state_d = `PDMC_S_RUN; // finish settle, then hw standby
			end
			`PDMC_S_HWSTBY: begin
				state_d = `PDMC_S_HWSTBY; // left only by power-on reset
			end
			default: begin
				state_d = `PDMC_S_RUN;
			end
		endcase
		if (mreset_ok)
			state_d = `PDMC_S_RUN; // manual reset ends sleep or standby
	end

	// mode register, exception start and event codes
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q         <= `PDMC_S_RUN; // power-on reset ends any mode
			exception_start <= 1'b0;
			evt_a_q         <= `PDMC_EVT_RST;
			evt_b_q         <= `PDMC_EVT_RST;
			pwake_q         <= 1'b0;
		end else if (ce) begin
			state_q         <= state_d;
			exception_start <= 1'b0;
			if (!mreset_ok && ((state_q == `PDMC_S_SLEEP && sleep_wake && !hw_req)
				|| (state_q == `PDMC_S_SETTLE && settle_done))) begin
				exception_start <= 1'b1;
				evt_a_q         <= irq_code;
				evt_b_q         <= irq_code;
			end
			// post-wake count armed at settle end
			if (mreset_ok)
				pwake_q <= 1'b0;
			else if (state_q == `PDMC_S_SETTLE && settle_done)
				pwake_q <= 1'b1;
			else if (!standby_select_bit_q || state_d == `PDMC_S_SWSTBY || state_d == `PDMC_S_HWSTBY)
				pwake_q <= 1'b0;
		end
	end

	// ****************************************************************
	// mode outputs and clock gates
	// ****************************************************************
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			power_state_pin_hi <= 1'b0;
			power_state_pin_lo <= 1'b0;
			clock_output_en    <= 1'b1;
			cpu_clk_en         <= 1'b1;
			periph_clk_en      <= 1'b1;
			module_clk_en      <= ~`PDMC_MSTOP_RST;
			hw_standby_active  <= 1'b0;
			manual_reset_req   <= 1'b0;
			event_code         <= `PDMC_EVT_RST;
		end else if (ce) begin
			power_state_pin_hi <= (state_d == `PDMC_S_SLEEP);
			power_state_pin_lo <= (state_d == `PDMC_S_SWSTBY);
			// clock out runs in sleep, stops in standby
			clock_output_en    <= (state_d == `PDMC_S_RUN)
				|| (state_d == `PDMC_S_SLEEP);
			cpu_clk_en         <= (state_d == `PDMC_S_RUN);
			periph_clk_en      <= (state_d == `PDMC_S_RUN)
				|| (state_d == `PDMC_S_SLEEP);
			if ((state_d == `PDMC_S_RUN) || (state_d == `PDMC_S_SLEEP))
				module_clk_en <= ~mstop_q;
			else
				module_clk_en <= {`PDMC_MSTOP_W{1'b0}};
			hw_standby_active  <= (state_d == `PDMC_S_HWSTBY);
			manual_reset_req   <= mreset_ok;
			event_code         <= evt_a_q;
		end
	end

	// ****************************************************************
	// watchdog counter for settling and post-wake re-entry
	// ****************************************************************
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_q <= `PDMC_PRE_RST;
			cnt_q <= `PDMC_CNT_RST;
		end else if (ce) begin
			if (cnt_run)
				pre_q <= pre_q + 16'h0001;
			else
				pre_q <= `PDMC_PRE_RST;
			// a software write wins over counting
			if (do_write && aw_addr_q == `PDMC_OFS_WDOG_CNT)
				cnt_q <= wmix_cnt[`PDMC_CNT_W-1:0];
			else if (cnt_run && tick)
				cnt_q <= cnt_q + 8'h01;
		end
	end

	// ****************************************************************
	// axi4-lite write path and control registers
	// ****************************************************************
	assign do_write  = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wmix_standby_select_bit  = wmerge({30'h0, rtc_use_q, standby_select_bit_q}, w_data_q, w_strb_q);
	assign wmix_mstop = wmerge({16'h0, mstop_q}, w_data_q, w_strb_q);
	assign wmix_wctl  = wmerge({24'h0, wdog_run_q, 4'h0, wdog_sel_q}, w_data_q, w_strb_q);
	assign wmix_cnt   = wmerge({24'h0, cnt_q}, w_data_q, w_strb_q);

	// address and data in either order, answer after both
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PDMC_RESP_OKAY;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
			standby_select_bit_q        <= 1'b0;
			rtc_use_q     <= 1'b0;
			mstop_q       <= `PDMC_MSTOP_RST;
			wdog_run_q    <= 1'b0;
			wdog_sel_q    <= 3'h0;
		end else if (ce) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (s_axi_awvalid && !s_axi_awready && !aw_have_q) begin
				s_axi_awready <= 1'b1;
				aw_have_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !s_axi_wready && !w_have_q) begin
				s_axi_wready <= 1'b1;
				w_have_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_write) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `PDMC_RESP_OKAY;
				case (aw_addr_q)
					`PDMC_OFS_STANDBY_SELECT_BIT_CTRL: begin
						standby_select_bit_q    <= wmix_standby_select_bit[`PDMC_STANDBY_SELECT_BIT_BIT];
						rtc_use_q <= wmix_standby_select_bit[`PDMC_RTC_USE_BIT];
					end
					`PDMC_OFS_MSTOP: begin
						mstop_q <= wmix_mstop[`PDMC_MSTOP_W-1:0];
					end
					`PDMC_OFS_WDOG_CTRL: begin
						wdog_run_q <= wmix_wctl[`PDMC_WDOG_RUN_BIT];
						wdog_sel_q <= wmix_wctl[`PDMC_WDOG_SEL_HI:`PDMC_WDOG_SEL_LO];
					end
					`PDMC_OFS_WDOG_CNT: begin
						s_axi_bresp <= `PDMC_RESP_OKAY;
					end
					`PDMC_OFS_STATUS, `PDMC_OFS_EVT_A, `PDMC_OFS_EVT_B: begin
						s_axi_bresp <= `PDMC_RESP_OKAY; // read-only, write dropped
					end
					default: begin
						s_axi_bresp <= `PDMC_RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// axi4-lite read path
	// ****************************************************************
	// read data mux
	always @* begin
		rd_d   = 32'h00000000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`PDMC_OFS_STANDBY_SELECT_BIT_CTRL: rd_d = {30'h0, rtc_use_q, standby_select_bit_q};
			`PDMC_OFS_MSTOP:     rd_d = {16'h0, mstop_q}; // read-back
			`PDMC_OFS_WDOG_CTRL: rd_d = {24'h0, wdog_run_q, 4'h0, wdog_sel_q};
			`PDMC_OFS_WDOG_CNT:  rd_d = {24'h0, cnt_q};
			`PDMC_OFS_STATUS:    rd_d = {26'h0, hw_req, pwake_q, 1'b0, state_q};
			`PDMC_OFS_EVT_A:     rd_d = {20'h0, evt_a_q};
			`PDMC_OFS_EVT_B:     rd_d = {20'h0, evt_b_q};
			default:             rd_hit = 1'b0;
		endcase
	end

	// one read at a time, answer next cycle
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `PDMC_RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_d;
				s_axi_rresp   <= rd_hit ? `PDMC_RESP_OKAY : `PDMC_RESP_SLVERR;
			end
		end
	end

endmodule // pdmc_top

`default_nettype wire

// ---- bench/pdmc_sva.sv ----
// concurrent checks on the power-down mode controller ports
// assumes one clk domain, reset_n async active low
`default_nettype none

module pdmc_sva (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        ce,
	// cpu, interrupt and reset inputs
	input wire logic        sleep_exec,
	input wire logic        nmi_irq,
	input wire logic        ext_irq,
	input wire logic        encoded_level_irq,
	input wire logic        port_irq,
	input wire logic        periph_irq,
	input wire logic        manual_reset_n,
	// mode outputs
	input wire logic        power_state_pin_hi,
	input wire logic        power_state_pin_lo,
	input wire logic        clock_output_en,
	input wire logic        cpu_clk_en,
	input wire logic        periph_clk_en,
	input wire logic [15:0] module_clk_en,
	input wire logic        exception_start,
	input wire logic        hw_standby_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// ****************************************************************
	// mode sequences
	// ****************************************************************
	wire go = ce && manual_reset_n;
	wire wake = nmi_irq | ext_irq | encoded_level_irq | port_irq | periph_irq;
	sequence s_sleep;
		power_state_pin_hi && !power_state_pin_lo;
	endsequence
	sequence s_swstby;
		!power_state_pin_hi && power_state_pin_lo;
	endsequence
	sequence s_run;
		cpu_clk_en && !power_state_pin_hi && !power_state_pin_lo;
	endsequence
	sequence s_dark;
		!cpu_clk_en && !clock_output_en && !periph_clk_en && module_clk_en == 16'h0000;
	endsequence
	// sleep halts only the cpu
	AST_SLEEP_OUT: assert property (s_sleep |-> clock_output_en && periph_clk_en && !cpu_clk_en)
		else $error("sleep outputs wrong");
	// standby stops all clocks
	AST_SWSTBY_OUT: assert property (s_swstby |-> s_dark)
		else $error("standby clock on");
	// sleep instruction leaves run
	AST_ENTRY: assert property (s_run ##0 (sleep_exec && go) |=> power_state_pin_hi ^ power_state_pin_lo)
		else $error("sleep ignored");
	// sleep wake takes exception
	AST_SLEEP_WAKE: assert property (s_sleep ##0 (wake && go) |=> s_run ##0 exception_start)
		else $error("sleep wake missing");
	// exception start lasts one cycle
	AST_EXC_PULSE: assert property (exception_start && ce |=> !exception_start)
		else $error("exception too long");
	// manual reset ends sleep
	AST_SLEEP_MRST: assert property (s_sleep ##0 (ce && !manual_reset_n) |=> s_run)
		else $error("manual reset kept sleep");
	// nmi starts settle, clocks off
	AST_SW_NMI: assert property (s_swstby ##0 (nmi_irq && go) |=> !power_state_pin_lo && !cpu_clk_en)
		else $error("standby nmi wake wrong");
	// hw standby stays dark
	AST_HW_HOLD: assert property (hw_standby_active |=> hw_standby_active ##0 s_dark ##0 !power_state_pin_hi)
		else $error("hw standby left or lit");
	// hw standby: no exception
	AST_HW_NOEXC: assert property (hw_standby_active |-> !exception_start && !power_state_pin_lo)
		else $error("exception in hw standby");
endmodule // pdmc_sva

bind pdmc_top pdmc_sva u_sva (.clk(clk), .reset_n(reset_n), .ce(ce), .sleep_exec(sleep_exec),
	.nmi_irq(nmi_irq), .ext_irq(ext_irq), .encoded_level_irq(encoded_level_irq),
	.port_irq(port_irq), .periph_irq(periph_irq), .manual_reset_n(manual_reset_n),
	.power_state_pin_hi(power_state_pin_hi), .power_state_pin_lo(power_state_pin_lo),
	.clock_output_en(clock_output_en), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
	.module_clk_en(module_clk_en), .exception_start(exception_start),
	.hw_standby_active(hw_standby_active));
`default_nettype wire

// ---- bench/pdmc_board.sv ----
// board model: rtc crystal, standby pin, power-on reset
// assumes one clk; the rtc level is synchronous to it
`default_nettype none

module pdmc_board #(
	parameter int RTC_HALF = 8,
	parameter int POR_HOLD = 1
) (
	// clock
	input  wire logic clk,
	// requests from the sequence
	input  wire logic hw_req,
	input  wire logic por_req,
	// pins to the controller
	output var logic  reset_n,
	output var logic  rtc_crystal_input,
	output var logic  hw_standby_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int rtc_cnt;
	int por_cnt;
	// ****************************************************************
	// pin drivers
	// ****************************************************************
	initial begin
		rtc_cnt = 0;
		por_cnt = POR_HOLD;
		reset_n = 1'b0;
		rtc_crystal_input = 1'b0;
		hw_standby_pin = 1'b1;
	end
	// free-running rtc crystal
	always @(posedge clk) begin
		rtc_cnt <= (rtc_cnt == RTC_HALF - 1) ? 0 : rtc_cnt + 1;
		if (rtc_cnt == RTC_HALF - 1) begin
			rtc_crystal_input <= !rtc_crystal_input;
		end
	end
	// reset hold, pin raised under it
	always @(posedge clk) begin
		if (por_req) begin
			reset_n <= 1'b0;
			por_cnt <= POR_HOLD;
		end else if (por_cnt != 0) begin
			por_cnt <= por_cnt - 1;
			hw_standby_pin <= 1'b1;
		end else begin
			reset_n <= 1'b1;
			if (hw_req) begin
				hw_standby_pin <= 1'b0;
			end
		end
	end
endmodule // pdmc_board
`default_nettype wire

// ---- bench/test_power_down_mode_controller.sv ----
// self-checking bench of the power-down mode controller
// assumes pdmc_top, pdmc_board and the map header on the include path
`default_nettype none
`include "pdmc_map.vh"

module test_power_down_mode_controller;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, ce = 1, hw_req = 0, por_req = 0, sleep_exec = 0, rtc = 0, mrst_n = 1;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [3:0]  wstrb = 0;
	logic [4:0]  irqs = 0;
	logic [11:0] code = 0, event_code;
	logic [1:0]  bresp, rresp, rr;
	logic        awready, wready, bvalid, arready, rvalid, reset_n, rtc_ck, hw_pin;
	logic        hi, lo, ckout, cpuck, perck, exc, mreq, hwact;
	logic [15:0] modck;
	int          mismatches = 0, total_checks = 0, cycles = 0;

	pdmc_board board (.clk(clk), .hw_req(hw_req), .por_req(por_req), .reset_n(reset_n),
		.rtc_crystal_input(rtc_ck), .hw_standby_pin(hw_pin));
	pdmc_top dut (.clk(clk), .reset_n(reset_n), .ce(ce), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sleep_exec(sleep_exec), .nmi_irq(irqs[0]), .ext_irq(irqs[1]),
		.encoded_level_irq(irqs[2]), .port_irq(irqs[3]), .periph_irq(irqs[4]), .rtc_irq(rtc),
		.irq_code(code), .manual_reset_n(mrst_n), .rtc_crystal_input(rtc_ck),
		.hw_standby_pin(hw_pin), .power_state_pin_hi(hi), .power_state_pin_lo(lo),
		.clock_output_en(ckout), .cpu_clk_en(cpuck), .periph_clk_en(perck),
		.module_clk_en(modck), .exception_start(exc), .event_code(event_code),
		.manual_reset_req(mreq), .hw_standby_active(hwact));

	// ****************************************************************
	// clock, timeout, tasks
	// ****************************************************************
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// axi4-lite write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		check(bresp, `PDMC_RESP_OKAY);
		@(posedge clk);
	endtask
	// axi4-lite read
	task automatic rdr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		rr = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic await(ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		check(s, v);
	endtask
	task automatic sleep_now;
		sleep_exec <= 1'b1;
		@(posedge clk);
		sleep_exec <= 1'b0;
		@(posedge clk);
	endtask

	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial begin
		wait (reset_n === 1'b1);
		@(posedge clk);
		check(modck, 16'hffff);
		rdr(`PDMC_OFS_MSTOP);
		check(rd, 32'h0);
		wr(`PDMC_OFS_MSTOP, 32'h8001);
		check(modck, 16'h7ffe);
		wr(`PDMC_OFS_MSTOP, 32'h0);
		rdr(`PDMC_OFS_MSTOP);
		check(rd, 32'h0);
		check(modck, 16'hffff);
		rdr(8'h40);
		check({rd[29:0], rr}, {30'h0, `PDMC_RESP_SLVERR});
		$display("test module stop done");
		for (int i = 0; i < 5; i++) begin
			sleep_now();
			check({hi, lo, ckout, cpuck}, 4'b1010);
			code <= 12'h400 + 12'(i);
			irqs <= 5'(1 << i);
			await(exc, 1'b1, 20);
			irqs <= 5'h00;
			rdr(`PDMC_OFS_EVT_A);
			check(rd, 32'h400 + i);
			rdr(`PDMC_OFS_EVT_B);
			check(rd, 32'h400 + i);
		end
		sleep_now();
		mrst_n <= 1'b0;
		repeat (2) @(posedge clk);
		check({cpuck, hi, mreq}, 3'b101);
		mrst_n <= 1'b1;
		$display("test sleep done");
		wr(`PDMC_OFS_WDOG_CTRL, 32'h0);
		wr(`PDMC_OFS_WDOG_CNT, 32'hf0);
		wr(`PDMC_OFS_STANDBY_SELECT_BIT_CTRL, 32'h1);
		sleep_now();
		check({hi, lo, ckout, perck, modck}, 20'h40000);
		irqs <= 5'h02;
		repeat (20) @(posedge clk);
		check(lo, 1'b1);
		code <= 12'h1c0;
		irqs <= 5'h01;
		await(exc, 1'b1, 60);
		irqs <= 5'h00;
		check({hi, lo, cpuck}, 3'b001);
		wr(`PDMC_OFS_STANDBY_SELECT_BIT_CTRL, 32'h3);
		await(lo, 1'b1, 200);
		code <= 12'h4a0;
		rtc <= 1'b1;
		await(exc, 1'b1, 300);
		rtc <= 1'b0;
		wr(`PDMC_OFS_STANDBY_SELECT_BIT_CTRL, 32'h0);
		repeat (300) @(posedge clk);
		rdr(`PDMC_OFS_STATUS);
		check(rd[2:0], `PDMC_S_RUN);
		rdr(`PDMC_OFS_EVT_A);
		check(rd, 32'h4a0);
		check(event_code, 12'h4a0);
		$display("test software standby done");
		wr(`PDMC_OFS_MSTOP, 32'h0003);
		sleep_now();
		hw_req <= 1'b1;
		await(hwact, 1'b1, 100);
		irqs <= 5'h01;
		mrst_n <= 1'b0;
		repeat (10) @(posedge clk);
		check({hwact, cpuck, ckout, hi, lo, exc, mreq}, 7'b1000000);
		irqs <= 5'h00;
		mrst_n <= 1'b1;
		hw_req <= 1'b0;
		por_req <= 1'b1;
		@(posedge clk);
		por_req <= 1'b0;
		wait (reset_n === 1'b0);
		wait (reset_n === 1'b1);
		@(posedge clk);
		check({hwact, cpuck}, 2'b01);
		rdr(`PDMC_OFS_MSTOP);
		check(rd, 32'h0);
		$display("test hardware standby done");
		end_of_test();
	end
endmodule // test_power_down_mode_controller
`default_nettype wire
